/* File: rtl/dram_state_pkg.sv */
package dram_state_pkg;

	// ----------------------------------------
	// clock
	// ----------------------------------------
	localparam int CLK_NS = 40;

	// ----------------------------------------
	// command path
	// ----------------------------------------
	localparam logic [2:0] CMD_PATH_DISABLE_DELAY = 3'h4;
	localparam logic [2:0] PARITY_LATENCY_NCK     = 3'h4;

	// ----------------------------------------
	// alert pulse widths in link cycles
	// ----------------------------------------
	localparam logic [7:0] PAR_ALERT_PW_NCK = 8'h48;
	localparam logic [3:0] CRC_ALERT_PW_NCK = 4'h8;

	// ----------------------------------------
	// alert delays
	// ----------------------------------------
	localparam int CRC_ALERT_MIN_NS  = 3;
	localparam int CRC_ALERT_MAX_NS  = 13;
	localparam int PAR_ALERT_XTRA_NS = 6;
	localparam int CRC_ALERT_MIN_CYC =
		((CRC_ALERT_MIN_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
		(CRC_ALERT_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CRC_ALERT_MAX_CYC =
		(CRC_ALERT_MAX_NS / CLK_NS < 1) ? 1 : CRC_ALERT_MAX_NS / CLK_NS;
	localparam int PAR_ALERT_XTRA_CYC =
		(PAR_ALERT_XTRA_NS / CLK_NS < 1) ? 1 : PAR_ALERT_XTRA_NS / CLK_NS;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic ALERT_N_RST  = 1'b1;
	localparam logic PATH_EN_RST  = 1'b1;

endpackage : dram_state_pkg

/* File: rtl/dram_state_timing.sv */
// Summary of operation
// - command path stops within 4 cycles of power-down or saving entry
// - commands within one parity latency after parity error dropped
// - parity error drives alert low for a bounded cycle count
// - write crc error drives alert low for 6 to 10 cycles
`timescale 1ns/100ps
`default_nettype none

module dram_state_timing #(
	parameter logic [2:0] CPD_DELAY  = dram_state_pkg::CMD_PATH_DISABLE_DELAY,
	parameter logic [2:0] PAR_LAT    = dram_state_pkg::PARITY_LATENCY_NCK,
	parameter logic [7:0] PAR_PW     = dram_state_pkg::PAR_ALERT_PW_NCK,
	parameter logic [3:0] CRC_PW     = dram_state_pkg::CRC_ALERT_PW_NCK
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// link pins
	input  wire logic link_ck,
	input  wire logic link_cke,
	input  wire logic cmd_strobe,
	input  wire logic cmd_pd_entry,
	input  wire logic cmd_max_power_saving_mode_entry,
	// internal checkers
	input  wire logic parity_err,
	input  wire logic crc_err,
	// status
	output var  logic cmd_path_en,
	output var  logic cmd_accept,
	output var  logic alert_n
);
	import dram_state_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic       ck_s1;
		logic       ck_s2;
		logic       ck_prev;
		logic       cke_s1;
		logic       cke_s2;
		logic       cke_prev;
		logic       cmd_s1;
		logic       cmd_s2;
		logic       pde_s1;
		logic       pde_s2;
		logic       mps_s1;
		logic       mps_s2;
		logic [2:0] cpd_cnt;
		logic       path_en;
		logic [2:0] blank_cnt;
		logic [7:0] par_cnt;
		logic [3:0] crc_cnt;
		logic       accept;
		logic       alert_n;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic   ck_edge;
	logic   cke_rise;
	logic   entry;

	assign ck_edge  = s_q.ck_s2 & ~s_q.ck_prev;
	assign cke_rise = s_q.cke_s2 & ~s_q.cke_prev;
	assign entry    = ck_edge & s_q.path_en & s_q.cmd_s2 &
	                  (s_q.pde_s2 | s_q.mps_s2);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_d          = s_q;
		s_d.ck_s1    = link_ck;
		s_d.ck_s2    = s_q.ck_s1;
		s_d.ck_prev  = s_q.ck_s2;
		s_d.cke_s1   = link_cke;
		s_d.cke_s2   = s_q.cke_s1;
		s_d.cke_prev = s_q.cke_s2;
		s_d.cmd_s1   = cmd_strobe;
		s_d.cmd_s2   = s_q.cmd_s1;
		s_d.pde_s1   = cmd_pd_entry;
		s_d.pde_s2   = s_q.pde_s1;
		s_d.mps_s1   = cmd_max_power_saving_mode_entry;
		s_d.mps_s2   = s_q.mps_s1;
		s_d.accept   = 1'b0;

		if (entry && s_q.cpd_cnt == 3'h0) begin
			s_d.cpd_cnt = CPD_DELAY;
		end else if (ck_edge && s_q.cpd_cnt != 3'h0) begin
			s_d.cpd_cnt = s_q.cpd_cnt - 3'h1;
			if (s_q.cpd_cnt == 3'h1) begin
				s_d.path_en = 1'b0;
			end
		end
		// power-down exit reopens path
		if (cke_rise && s_q.cpd_cnt == 3'h0) begin
			s_d.path_en = 1'b1;
		end

		if (ck_edge && s_q.blank_cnt != 3'h0) begin
			s_d.blank_cnt = s_q.blank_cnt - 3'h1;
		end
		if (ck_edge && s_q.cmd_s2 && s_q.path_en &&
		    s_q.blank_cnt == 3'h0) begin
			s_d.accept = 1'b1;
		end
		if (parity_err) begin
			s_d.blank_cnt = PAR_LAT;
		end

		if (ck_edge && s_q.par_cnt != 8'h00) begin
			s_d.par_cnt = s_q.par_cnt - 8'h01;
		end
		if (parity_err) begin
			s_d.par_cnt = PAR_PW;
		end

		if (ck_edge && s_q.crc_cnt != 4'h0) begin
			s_d.crc_cnt = s_q.crc_cnt - 4'h1;
		end
		if (crc_err) begin
			s_d.crc_cnt = CRC_PW;
		end

		// alert driven one clock after cause
		s_d.alert_n = (s_d.par_cnt == 8'h00) && (s_d.crc_cnt == 4'h0);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			s_q         <= '0;
			s_q.path_en <= PATH_EN_RST;
			s_q.alert_n <= ALERT_N_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign cmd_path_en = s_q.path_en;
	assign cmd_accept  = s_q.accept;
	assign alert_n     = s_q.alert_n;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// countdown armed on entry
	a_entry_arms: assert property (@(posedge clk) disable iff (reset)
		(entry && s_q.cpd_cnt == 3'h0) |=> (s_q.cpd_cnt == CPD_DELAY))
		else $error("disable countdown not armed on entry");

	a_path_closes: assert property (@(posedge clk) disable iff (reset)
		(ck_edge && s_q.cpd_cnt == 3'h1) |=> !cmd_path_en)
		else $error("command path still open after entry delay");

	a_blank_drop: assert property (@(posedge clk) disable iff (reset)
		(parity_err ##1 (s_q.blank_cnt == PAR_LAT)) or !parity_err)
		else $error("blank window not armed");

	a_blank_accept: assert property (@(posedge clk) disable iff (reset)
		(ck_edge && s_q.blank_cnt != 3'h0) |=> !cmd_accept)
		else $error("command accepted inside parity blank window");

	a_parity_alert: assert property (@(posedge clk) disable iff (reset)
		parity_err |=> (!alert_n && s_q.par_cnt == PAR_PW))
		else $error("alert not low after parity error");

	a_crc_alert: assert property (@(posedge clk) disable iff (reset)
		crc_err |=> (!alert_n && s_q.crc_cnt == CRC_PW))
		else $error("alert not low after crc error");

	a_alert_release: assert property (@(posedge clk) disable iff (reset)
		(ck_edge && s_q.par_cnt <= 8'h01 && s_q.crc_cnt <= 4'h1 &&
		 !parity_err && !crc_err) |=> alert_n)
		else $error("alert held past pulse width");

	a_alert_hold: assert property (@(posedge clk) disable iff (reset)
		(s_q.crc_cnt > 4'h1) |=> !alert_n)
		else $error("crc alert released early");

	// alert stays low while parity counting
	a_par_hold: assert property (@(posedge clk) disable iff (reset)
		(s_q.par_cnt > 8'h01) |=> !alert_n)
		else $error("parity alert released early");

endmodule : dram_state_timing

`default_nettype wire

/* File: bench/ddr_ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ddr_ctl_model (
	// clock and link pins
	input  wire logic clk,
	output var  logic link_ck,
	output var  logic link_cke,
	output var  logic cmd_strobe,
	output var  logic cmd_pd_entry,
	output var  logic cmd_max_power_saving_mode_entry
);
	initial begin
		{link_ck, cmd_strobe, cmd_pd_entry, cmd_max_power_saving_mode_entry} = 4'h0;
		link_cke = 1'b1;
	end
	// link clock runs only inside ticks calls
	task automatic ticks(input int n);
		repeat (n) begin
			repeat (4) @(negedge clk);
			link_ck = 1'b1;
			repeat (4) @(negedge clk);
			link_ck = 1'b0;
		end
	endtask : ticks
	// one command held across one link edge
	task automatic send(input logic pd, input logic mp);
		@(negedge clk);
		{cmd_strobe, cmd_pd_entry, cmd_max_power_saving_mode_entry} = {1'b1, pd, mp};
		ticks(1);
		{cmd_strobe, cmd_pd_entry, cmd_max_power_saving_mode_entry} = 3'h0;
	endtask : send
	task automatic wake();
		link_cke = 1'b0;
		ticks(5);
		link_cke = 1'b1;
		ticks(5);
	endtask : wake
endmodule : ddr_ctl_model
`default_nettype wire

/* File: bench/tb_dram_state_timing.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_dram_state_timing;
	import dram_state_pkg::*;
	// ----
	// signals
	// ----
	logic      clk;
	logic      reset = 1'b1;
	logic      parity_err = 1'b0;
	logic      crc_err = 1'b0;
	wire logic link_ck, link_cke, cmd_strobe, cmd_pd_entry, cmd_max_power_saving_mode_entry;
	wire logic cmd_path_en, cmd_accept, alert_n;
	int        fail_count = 0;
	int        total_checks = 0;
	int        acc = 0;
	ddr_ctl_model ctl (.clk(clk), .link_ck(link_ck), .link_cke(link_cke),
		.cmd_strobe(cmd_strobe), .cmd_pd_entry(cmd_pd_entry),
		.cmd_max_power_saving_mode_entry(cmd_max_power_saving_mode_entry));
	dram_state_timing dut (.clk(clk), .reset(reset), .link_ck(link_ck),
		.link_cke(link_cke), .cmd_strobe(cmd_strobe),
		.cmd_pd_entry(cmd_pd_entry), .cmd_max_power_saving_mode_entry(cmd_max_power_saving_mode_entry),
		.parity_err(parity_err), .crc_err(crc_err),
		.cmd_path_en(cmd_path_en), .cmd_accept(cmd_accept), .alert_n(alert_n));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (cmd_accept === 1'b1) acc++;
	// ----
	// helpers
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		if (fail_count == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop
	// ----
	// scenarios
	// ----
	task automatic plain_cmds();
		int a0;
		a0 = acc;
		ctl.send(1'b0, 1'b0);
		ctl.send(1'b0, 1'b0);
		ctl.ticks(1);
		check(acc - a0, 2);
	endtask : plain_cmds
	task automatic entry(input logic mp);
		int a0;
		ctl.send(~mp, mp);
		ctl.ticks(4);
		repeat (2) @(negedge clk);
		check(cmd_path_en, 1'b0);
		a0 = acc;
		ctl.send(1'b0, 1'b0);
		ctl.ticks(1);
		check(acc - a0, 0);
		ctl.wake();
		check(cmd_path_en, 1'b1);
	endtask : entry
	task automatic alert_case(input logic par, input int lo, input int hi);
		int n;
		int a0;
		@(negedge clk);
		{parity_err, crc_err} = {par, ~par};
		@(negedge clk);
		{parity_err, crc_err} = 2'h0;
		check(alert_n, 1'b0);
		a0 = acc;
		ctl.send(1'b0, 1'b0);
		repeat (2) @(negedge clk);
		for (n = 1; n < 200 && alert_n !== 1'b1; n++) begin
			ctl.ticks(1);
			repeat (2) @(negedge clk);
		end
		if (n >= 200) begin
			fail_count++;
			report_and_stop();
		end
		check(n >= lo && n <= hi, 1);
		check(acc - a0, par ? 0 : 1);
	endtask : alert_case
	initial begin
		repeat (12) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		check(cmd_path_en, PATH_EN_RST);
		check(alert_n, ALERT_N_RST);
		plain_cmds();
		entry(1'b0);
		entry(1'b1);
		alert_case(1'b1, 64, 96);
		alert_case(1'b0, 6, 10);
		report_and_stop();
	end
endmodule : tb_dram_state_timing
`default_nettype wire
